/* dcff_map.vh */
/*
 * constants for the dual clock flagged fifo: widths, depth, defaults,
 * register offsets and pin vector layout.
 * assumes inclusion by dcff_top.v only; definitions only.
 */
// How it works
// - both data ports carry 18-bit words
// - master clear zeroes pointers and output register
// - master clear latches mode, default offset, method
// - partial clear zeroes pointers, keeps settings
// - reread request rewinds read pointer only
// - reread forces empty low or ready high
// - mode pin during master clear picks timing
// - mode pin after clear is serial input
// - enabled write stores word or offset
// - serial enable shifts one offset bit
// - enabled read delivers word or offset
// - output enable drives or floats data bus
// - load pin at master clear picks default offset
// - load pin steers cycles to offset registers
// - standard mode: flag shows memory full
// - fall-through mode: flag shows space available
// - standard mode: flag shows memory empty
// - fall-through mode: flag shows output valid
// - almost-full low above capacity minus m
// - almost-empty low below offset n
// - half flag shows above half capacity
// - depth is 32768 words of 18 bits
// - fall-through first word appears without read
// - 127 pairs parallel, 1023 pairs serial
// - standard first word needs explicit read
`ifndef DCFF_MAP_VH
`define DCFF_MAP_VH
`define DCFF_DW 18
`define DCFF_AW 15
`define DCFF_PW 16
`define DCFF_DEPTH 16'h8000
`define DCFF_HALF 16'h4000
`define DCFF_OFS_LO 15'h007F
`define DCFF_OFS_HI 15'h03FF
`define DCFF_FT_WAIT 2'h1
`define DCFF_PIN_W 29
`define DCFF_PIN_IDLE 29'h077C0000
`define DCFF_ADR_STATUS 8'h00
`define DCFF_ADR_COUNT 8'h04
`define DCFF_ADR_EOFS 8'h08
`define DCFF_ADR_FOFS 8'h0C
`define DCFF_ADR_CTRL 8'h10
`define DCFF_CTRL_PCLR 0
`endif

/* dcff_top.v */
/*
 * dual clock flagged fifo, 32768 x 18, with offset registers, partial
 * clear, reread and standard or fall-through timing.
 * assumes: all pins are asynchronous and are sampled on core_clk_i;
 * pin clocks run below a quarter of core_clk_i and every pin is steady
 * for two core cycles around each pin clock rising edge.
 */
// The address map and the Wishbone slave port were chosen for this implementation.
`timescale 1ns/10ps
`include "dcff_map.vh"
module dcff_top (
  input wire core_clk_i, // 50 MHz core clock
  input wire rst_b_i, // async reset, active low
  input wire wr_clk_pin_i, // writer clock pin
  input wire rd_clk_pin_i, // reader clock pin
  input wire master_clear_in_n_i, // master clear, low active
  input wire partial_clear_in_n_i, // partial clear, low active
  input wire reread_request_n_i, // reread, low active
  input wire fallthrough_select_serial_in_i, // mode strap, then serial data
  input wire write_enable_n_i, // write enable, low active
  input wire serial_shift_enable_n_i, // serial shift enable, low active
  input wire offset_access_select_n_i, // load pin, low active
  input wire read_enable_n_i, // read enable, low active
  input wire output_enable_n_i, // data bus enable, low active
  input wire [17:0] write_data_bus_i, // write data
  output wire [17:0] read_data_bus_o, // read data
  output wire read_data_bus_oe_o, // high while bus driven
  output wire full_or_input_ready_n_o, // full flag or input ready
  output wire empty_or_output_ready_n_o, // empty flag or output ready
  output wire almost_full_flag_n_o, // almost full, low active
  output wire almost_empty_flag_n_o, // almost empty, low active
  output wire half_level_flag_n_o, // above half, low active
  input wire wb_cyc_i, // wishbone cycle
  input wire wb_stb_i, // wishbone strobe
  input wire wb_we_i, // wishbone write
  input wire [7:0] wb_adr_i, // wishbone byte address
  input wire [3:0] wb_sel_i, // wishbone byte selects
  input wire [31:0] wb_dat_i, // wishbone write data
  output wire [31:0] wb_dat_o, // wishbone read data
  output wire wb_ack_o // wishbone acknowledge
);

  // pin synchronisers
  wire [`DCFF_PIN_W-1:0] pin_raw;
  reg [`DCFF_PIN_W-1:0] pin_s1_q;
  reg [`DCFF_PIN_W-1:0] pin_s2_q;
  reg wclk_d_q;
  reg rclk_d_q;

  assign pin_raw = {wr_clk_pin_i, rd_clk_pin_i, master_clear_in_n_i, partial_clear_in_n_i,
                    reread_request_n_i, fallthrough_select_serial_in_i, write_enable_n_i,
                    serial_shift_enable_n_i, offset_access_select_n_i, read_enable_n_i,
                    output_enable_n_i, write_data_bus_i};

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      // idle pin levels, so no clear or enable is seen after reset
      pin_s1_q <= `DCFF_PIN_IDLE;
      pin_s2_q <= `DCFF_PIN_IDLE;
      wclk_d_q <= 1'b0;
      rclk_d_q <= 1'b0;
    end else begin
      pin_s1_q <= pin_raw;
      pin_s2_q <= pin_s1_q;
      wclk_d_q <= pin_s2_q[28];
      rclk_d_q <= pin_s2_q[27];
    end
  end

  wire wclk_s = pin_s2_q[28];
  wire rclk_s = pin_s2_q[27];
  wire mclr = ~pin_s2_q[26];
  wire pclr_pin = ~pin_s2_q[25];
  wire rt = ~pin_s2_q[24];
  wire si = pin_s2_q[23];
  wire wen = ~pin_s2_q[22];
  wire serial_shift_enable_n = ~pin_s2_q[21];
  wire ld = ~pin_s2_q[20];
  wire ren = ~pin_s2_q[19];
  wire oe = ~pin_s2_q[18];
  wire [17:0] din = pin_s2_q[17:0];
  wire wr_edge = wclk_s & ~wclk_d_q;
  wire rd_edge = rclk_s & ~rclk_d_q;

  // state
  reg [17:0] mem [0:32767];
  reg [`DCFF_PW-1:0] wptr_q;
  reg [`DCFF_PW-1:0] rptr_q;
  reg [17:0] dout_q;
  reg valid_q;
  reg [1:0] ft_wait_q;
  reg rt_busy_q;
  reg ft_mode_q;
  reg serial_q;
  reg [`DCFF_AW-1:0] eofs_q;
  reg [`DCFF_AW-1:0] fofs_q;
  reg wsel_q;
  reg rsel_q;
  reg pclr_sw_q;
  reg ack_q;
  reg [31:0] rdat_q;

  wire [`DCFF_PW-1:0] count = wptr_q - rptr_q;
  wire full = (count == `DCFF_DEPTH);
  wire empty = (count == {`DCFF_PW{1'b0}});
  wire pclr = pclr_pin | pclr_sw_q;
  wire [`DCFF_AW-1:0] waddr = wptr_q[`DCFF_AW-1:0];
  wire [`DCFF_AW-1:0] raddr = rptr_q[`DCFF_AW-1:0];
  wire wr_mem = wr_edge & wen & ~ld & ~full;
  wire wr_par = wr_edge & wen & ld & ~serial_q;
  wire wr_ser = wr_edge & serial_shift_enable_n & serial_q;
  wire rd_ofs = rd_edge & ren & ld;
  // standard read, or fall-through advance/first-word load
  wire rd_std = rd_edge & ren & ~ld & ~ft_mode_q & ~empty & ~rt_busy_q;
  wire ft_take = rd_edge & ren & ~ld & valid_q & ~rt_busy_q;
  wire ft_load = ft_mode_q & ~rt_busy_q & ~empty &
                 ((~valid_q & rd_edge & (ft_wait_q == `DCFF_FT_WAIT)) | ft_take);
  wire rd_mem = rd_std | ft_load;

  // memory array
  always @(posedge core_clk_i) begin
    if (wr_mem) begin
      mem[waddr] <= din;
    end
  end

  // pointers, output register, fall-through valid
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wptr_q <= {`DCFF_PW{1'b0}};
      rptr_q <= {`DCFF_PW{1'b0}};
      dout_q <= 18'h00000;
      valid_q <= 1'b0;
      ft_wait_q <= 2'h0;
      rt_busy_q <= 1'b0;
      rsel_q <= 1'b0;
    end else if (mclr | pclr) begin
      wptr_q <= {`DCFF_PW{1'b0}};
      rptr_q <= {`DCFF_PW{1'b0}};
      dout_q <= 18'h00000;
      valid_q <= 1'b0;
      ft_wait_q <= 2'h0;
      rt_busy_q <= 1'b0;
      rsel_q <= 1'b0;
    end else begin
      if (wr_mem) begin
        wptr_q <= wptr_q + 16'h0001;
      end
      if (rd_edge & rt) begin
        rptr_q <= {wptr_q[15], 15'h0000};
        rt_busy_q <= 1'b1;
        valid_q <= 1'b0;
        ft_wait_q <= 2'h0;
      end else begin
        if (rd_edge) begin
          rt_busy_q <= 1'b0;
        end
        if (rd_ofs) begin
          dout_q <= {3'h0, rsel_q ? fofs_q : eofs_q};
          rsel_q <= ~rsel_q;
        end else if (rd_mem) begin
          dout_q <= mem[raddr];
          rptr_q <= rptr_q + 16'h0001;
        end
        if (ft_load) begin
          valid_q <= 1'b1;
        end else if (ft_take) begin
          valid_q <= 1'b0;
        end
        if (valid_q | empty | ~ft_mode_q) begin
          ft_wait_q <= 2'h0;
        end else if (rd_edge & (ft_wait_q != `DCFF_FT_WAIT)) begin
          ft_wait_q <= ft_wait_q + 2'h1;
        end
      end
    end
  end

  // configuration and offset registers
  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ft_mode_q <= 1'b0;
      serial_q <= 1'b0;
      eofs_q <= `DCFF_OFS_LO;
      fofs_q <= `DCFF_OFS_LO;
      wsel_q <= 1'b0;
    end else if (mclr) begin
      ft_mode_q <= si;
      serial_q <= ~ld;
      eofs_q <= ld ? `DCFF_OFS_LO : `DCFF_OFS_HI;
      fofs_q <= ld ? `DCFF_OFS_LO : `DCFF_OFS_HI;
      wsel_q <= 1'b0;
    end else if (pclr) begin
      wsel_q <= 1'b0;
    end else if (wr_par) begin
      if (wsel_q) begin
        fofs_q <= din[`DCFF_AW-1:0];
      end else begin
        eofs_q <= din[`DCFF_AW-1:0];
      end
      wsel_q <= ~wsel_q;
    end else if (wr_ser) begin
      {fofs_q, eofs_q} <= {si, fofs_q, eofs_q[`DCFF_AW-1:1]};
    end
  end

  // flags, active low
  wire [`DCFF_PW-1:0] af_lim = `DCFF_DEPTH - {1'b0, fofs_q};
  assign full_or_input_ready_n_o = ft_mode_q ? full : ~full;
  assign empty_or_output_ready_n_o = ft_mode_q ? (rt_busy_q | ~valid_q)
                                               : ~(rt_busy_q | empty);
  assign almost_full_flag_n_o = ~(count > af_lim);
  assign almost_empty_flag_n_o = ~(count < {1'b0, eofs_q});
  assign half_level_flag_n_o = ~(count > `DCFF_HALF);
  assign read_data_bus_o = dout_q;
  assign read_data_bus_oe_o = oe;

  // wishbone slave
  wire wb_req = wb_cyc_i & wb_stb_i & ~ack_q;
  reg [31:0] rd_mux;

  always @* begin
    rd_mux = 32'h00000000;
    case (wb_adr_i)
      `DCFF_ADR_STATUS: rd_mux = {24'h000000, serial_q, ft_mode_q, valid_q,
                                  rt_busy_q, full, empty, 2'h0};
      `DCFF_ADR_COUNT: rd_mux = {16'h0000, count};
      `DCFF_ADR_EOFS: rd_mux = {17'h00000, eofs_q};
      `DCFF_ADR_FOFS: rd_mux = {17'h00000, fofs_q};
      `DCFF_ADR_CTRL: rd_mux = 32'h00000000;
      default: rd_mux = 32'h00000000;
    endcase
  end

  always @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      pclr_sw_q <= 1'b0;
    end else begin
      ack_q <= wb_req;
      pclr_sw_q <= 1'b0;
      if (wb_req) begin
        rdat_q <= wb_we_i ? 32'h00000000 : rd_mux;
        if (wb_we_i & wb_sel_i[0] & (wb_adr_i == `DCFF_ADR_CTRL)) begin
          pclr_sw_q <= wb_dat_i[`DCFF_CTRL_PCLR];
        end
      end
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

endmodule // dcff_top

/* dcff_assertions.sv */
/* checker for dcff_top pins, data output and flags
   assumes bind into dcff_top; pins held steady several core cycles */
`timescale 1ns/10ps
module dcff_assertions (
  input wire core_clk_i, // clock
  input wire rst_b_i, // reset
  input wire master_clear_in_n_i, // clear
  input wire partial_clear_in_n_i, // clear
  input wire output_enable_n_i, // bus enable
  input wire rd_clk_pin_i, // read clock
  input wire wb_cyc_i, // bus cycle
  input wire [17:0] read_data_bus_o, // data
  input wire read_data_bus_oe_o, // data enable
  input wire full_or_input_ready_n_o, // flag
  input wire empty_or_output_ready_n_o, // flag
  input wire almost_full_flag_n_o, // flag
  input wire almost_empty_flag_n_o, // flag
  input wire half_level_flag_n_o // flag
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence mclr_s;
    (!master_clear_in_n_i)[*4];
  endsequence
  sequence pclr_s;
    (!partial_clear_in_n_i)[*4];
  endsequence
  sequence idle_s;
    (!rd_clk_pin_i && master_clear_in_n_i && partial_clear_in_n_i && !wb_cyc_i)[*7];
  endsequence
  AST_MCLR_OUT: assert property (mclr_s |-> read_data_bus_o == 18'h00000)
    else $error("output not zero in master clear");
  AST_PCLR_OUT: assert property (pclr_s |-> read_data_bus_o == 18'h00000)
    else $error("output not zero in partial clear");
  AST_MCLR_FLAGS: assert property (mclr_s |-> full_or_input_ready_n_o != empty_or_output_ready_n_o)
    else $error("flags wrong in master clear");
  AST_PCLR_FLAGS: assert property (pclr_s |-> full_or_input_ready_n_o != empty_or_output_ready_n_o)
    else $error("flags wrong in partial clear");
  AST_MCLR_LEVELS: assert property (mclr_s |-> !almost_empty_flag_n_o && half_level_flag_n_o && almost_full_flag_n_o)
    else $error("level flags wrong in master clear");
  AST_OE_ON: assert property ($fell(output_enable_n_i) |-> ##[1:3] read_data_bus_oe_o)
    else $error("bus not driven after enable");
  AST_OE_OFF: assert property (output_enable_n_i [*4] |-> !read_data_bus_oe_o)
    else $error("bus driven while disabled");
  AST_OUT_HOLD: assert property (idle_s |-> $stable(read_data_bus_o))
    else $error("output changed without read clock");
endmodule // dcff_assertions
bind dcff_top dcff_assertions dcff_assertions_i (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
  .master_clear_in_n_i(master_clear_in_n_i), .partial_clear_in_n_i(partial_clear_in_n_i),
  .output_enable_n_i(output_enable_n_i), .rd_clk_pin_i(rd_clk_pin_i), .wb_cyc_i(wb_cyc_i),
  .read_data_bus_o(read_data_bus_o), .read_data_bus_oe_o(read_data_bus_oe_o),
  .full_or_input_ready_n_o(full_or_input_ready_n_o),
  .empty_or_output_ready_n_o(empty_or_output_ready_n_o),
  .almost_full_flag_n_o(almost_full_flag_n_o), .almost_empty_flag_n_o(almost_empty_flag_n_o),
  .half_level_flag_n_o(half_level_flag_n_o));

/* dcff_pin_partner.sv */
/* writer and reader logic driving the pin side of dcff_top
   assumes core clock at four times or more the pin clock rate */
`timescale 1ns/10ps
module dcff_pin_partner (
  input wire core_clk_i, // core clock
  output logic wclk_o = 1'b0, // write clock pin
  output logic rclk_o = 1'b0, // read clock pin
  output logic wen_n_o = 1'b1, // write enable
  output logic sen_n_o = 1'b1, // serial enable
  output logic ren_n_o = 1'b1, // read enable
  output logic ld_n_o = 1'b1, // offset select
  output logic rt_n_o = 1'b1, // reread
  output logic si_o = 1'b0, // strap or serial bit
  output logic [17:0] d_o = 18'h00000 // write word
);
  task automatic strap(input logic f, l);
    @(posedge core_clk_i);
    si_o <= f;
    ld_n_o <= l;
  endtask
  task automatic wr(input logic w, s, l, b, input logic [17:0] v);
    @(posedge core_clk_i);
    wen_n_o <= ~w;
    sen_n_o <= ~s;
    ld_n_o <= ~l;
    si_o <= b;
    d_o <= v;
    repeat (2) @(posedge core_clk_i);
    wclk_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    wclk_o <= 1'b0;
    {wen_n_o, sen_n_o, ld_n_o} <= 3'h7;
    si_o <= ~b;
    d_o <= ~v; // released bus shows no stale word
    repeat (4) @(posedge core_clk_i);
  endtask
  task automatic rd(input logic r, l, t);
    @(posedge core_clk_i);
    ren_n_o <= ~r;
    ld_n_o <= ~l;
    rt_n_o <= ~t;
    repeat (2) @(posedge core_clk_i);
    rclk_o <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    rclk_o <= 1'b0;
    {ren_n_o, ld_n_o, rt_n_o} <= 3'h7;
    repeat (4) @(posedge core_clk_i);
  endtask
endmodule // dcff_pin_partner

/* tb_top.sv */
/* self-checking bench for dcff_top: pins through the partner, registers over wishbone
   assumes dcff_pin_partner drives every writer and reader pin except output enable, which the bench drives */
`timescale 1ns/10ps
module tb_top;
  logic clk = 1'b0, rst_b = 1'b0, mclr_n = 1'b1, pclr_n = 1'b1, oe_n = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, r;
  wire [31:0] dat_o;
  wire [17:0] q, d;
  wire ack, oe, ff, ef, af, ae, hf, wc, rc, wen, serial_shift_enable_n, ren, ld, rt, si;
  wire [4:0] flg = {ff, ef, af, ae, hf};
  int err_total = 0, total_checks = 0, i;
  initial forever #10 clk = ~clk;
  dcff_pin_partner p (.core_clk_i(clk), .wclk_o(wc), .rclk_o(rc), .wen_n_o(wen), .sen_n_o(serial_shift_enable_n),
    .ren_n_o(ren), .ld_n_o(ld), .rt_n_o(rt), .si_o(si), .d_o(d));
  dcff_top dcff_top_i (.core_clk_i(clk), .rst_b_i(rst_b), .wr_clk_pin_i(wc), .rd_clk_pin_i(rc),
    .master_clear_in_n_i(mclr_n), .partial_clear_in_n_i(pclr_n), .reread_request_n_i(rt),
    .fallthrough_select_serial_in_i(si), .write_enable_n_i(wen), .serial_shift_enable_n_i(serial_shift_enable_n),
    .offset_access_select_n_i(ld), .read_enable_n_i(ren), .output_enable_n_i(oe_n),
    .write_data_bus_i(d), .read_data_bus_o(q), .read_data_bus_oe_o(oe),
    .full_or_input_ready_n_o(ff), .empty_or_output_ready_n_o(ef), .almost_full_flag_n_o(af),
    .almost_empty_flag_n_o(ae), .half_level_flag_n_o(hf), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o),
    .wb_ack_o(ack));
  task automatic chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= v;
    do @(posedge clk); while (ack !== 1'b1);
    r = dat_o;
    {cyc, stb} <= 2'b00;
    @(posedge clk);
  endtask
  task automatic clear(input logic m, ft, ldn);
    p.strap(ft, ldn);
    {mclr_n, pclr_n} <= {~m, m};
    repeat (5) @(posedge clk);
    chk(q, 0);
    {mclr_n, pclr_n} <= 2'b11;
    repeat (4) @(posedge clk);
    p.strap(1'b0, 1'b1);
  endtask
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200_000;
    err_total++;
    report_and_stop;
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
    clear(1, 0, 0);
    chk(flg, 5'h15);
    p.wr(1, 0, 1, 0, 18'h00002);
    p.wr(1, 0, 1, 0, 18'h07FFE);
    p.rd(1, 1, 0);
    chk(q, 18'h00002);
    p.rd(1, 1, 0);
    chk(q, 18'h07FFE);
    for (i = 0; i < 3; i++) begin
      p.wr(1, 0, 0, 0, 18'h2A5A5 + i);
      chk(flg, i == 0 ? 5'h1D : i == 1 ? 5'h1F : 5'h1B);
    end
    chk(q, 18'h07FFE);
    p.rd(1, 0, 0);
    chk(q, 18'h2A5A5);
    p.rd(0, 0, 1);
    chk(ef, 0);
    for (i = 0; i < 5; i++) begin
      p.rd(1, 0, 0);
      chk(q, 18'h2A5A5 + (i == 0 ? 0 : i > 3 ? 2 : i - 1));
    end
    chk(flg, 5'h15);
    $display("test standard done");
    clear(0, 0, 0);
    p.rd(1, 1, 0);
    chk(q, 18'h00002);
    wb(0, 8'h0C, 0);
    chk(r, 32'h7FFE);
    wb(1, 8'h08, 32'h55);
    wb(0, 8'h08, 0);
    chk(r, 32'h2);
    wb(0, 8'h20, 0);
    chk(r, 0);
    p.wr(1, 0, 0, 0, 18'h0ABCD);
    wb(1, 8'h10, 1);
    wb(0, 8'h04, 0);
    chk(r, 0);
    oe_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(oe, 1);
    oe_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(oe, 0);
    $display("test clears done");
    clear(1, 1, 1);
    chk(flg, 5'h0D);
    wb(0, 8'h00, 0);
    chk(r & 32'hC0, 32'hC0);
    wb(0, 8'h0C, 0);
    chk(r, 32'h3FF);
    for (i = 0; i < 30; i++)
      p.wr(0, 1, 0, (30'h28003 >> i) & 1, 0);
    wb(0, 8'h08, 0);
    chk(r, 32'h3);
    wb(0, 8'h0C, 0);
    chk(r, 32'h5);
    p.wr(1, 0, 0, 0, 18'h1BEEF);
    p.rd(0, 0, 0);
    p.rd(0, 0, 0);
    chk(q, 18'h1BEEF);
    chk(ef, 0);
    p.rd(0, 0, 1);
    chk(ef, 1);
    p.rd(0, 0, 0);
    p.rd(0, 0, 0);
    chk(ef, 0);
    $display("test fall-through done");
    report_and_stop;
  end
endmodule // tb_top
